// file: verilog/cbu_top.sv
`timescale 1ns/1ps
`include "cbu_defs.svh"

module cbu_top
   import cbu_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic          instr_valid_i,
   input  wire logic [15:0]   instr_i,
   input  wire cbu_pc_t       pc_i,
   input  wire logic          flag_neg_i,
   input  wire logic          flag_carry_i,
   output      logic [1:0]    quarter_o,
   output      logic          pc_wr_o,
   output      cbu_pc_t       pc_val_o,
   output      logic          flush_o,
   output      logic          done_o,
   output      logic          taken_o
);

   logic [1:0]  q_q;
   cbu_state_e  state_q;
   logic        act_q;
   logic [15:0] word_q;
   cbu_pc_t     here_q;
   logic        neg_q;
   logic        carry_q;
   logic [7:0]  off_q;
   logic        taken_q;
   cbu_pc_t     target_q;
   cbu_pc_t     off_ext;
   logic        pc_wr_q;
   cbu_pc_t     pc_val_q;
   logic        flush_q;
   logic        done_q;

   cbu_dec_if dif ();

   // Decoder sees only the word and flags latched in Q1
   assign dif.word  = word_q;
   assign dif.neg   = neg_q;
   assign dif.carry = carry_q;

   cbu_decode u_decode (
      .dif (dif)
   );

   // Offset sign-extended and doubled to a byte distance
   assign off_ext = cbu_pc_t'({{(`CBU_PC_W-9){off_q[7]}}, off_q, 1'b0});

   // Free-running quarter counter; every edge ends one quarter
   always_ff @(posedge clk) begin
      if (srst) begin
         q_q <= `CBU_Q1;
      end else begin
         q_q <= q_q + 2'h1;
      end
   end

   // Cycle kind: a taken branch turns the next cycle into a no-op
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= CBU_ST_EXEC;
      end else if (q_q == `CBU_Q4) begin
         case (state_q)
            CBU_ST_EXEC: begin
               if (act_q && taken_q) begin
                  state_q <= CBU_ST_NOP;
               end
            end
            CBU_ST_NOP: begin
               state_q <= CBU_ST_EXEC;
            end
            default: begin
               state_q <= CBU_ST_EXEC;
            end
         endcase
      end
   end

   // Q1: latch word, address and flags; the prefetch is dropped in a no-op cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         act_q   <= 1'b0;
         word_q  <= `CBU_WORD_RST;
         here_q  <= `CBU_PC_RST;
         neg_q   <= 1'b0;
         carry_q <= 1'b0;
      end else if (q_q == `CBU_Q1) begin
         act_q <= instr_valid_i && (state_q == CBU_ST_EXEC);
         if (instr_valid_i && (state_q == CBU_ST_EXEC)) begin
            word_q  <= instr_i;
            here_q  <= pc_i;
            neg_q   <= flag_neg_i;
            carry_q <= flag_carry_i;
         end
      end else if ((q_q == `CBU_Q4) && act_q && taken_q) begin
         act_q <= 1'b0;
      end else if ((q_q == `CBU_Q4) && !act_q) begin
         act_q <= 1'b0;
      end
   end

   // Q2: read the literal and settle the condition
   always_ff @(posedge clk) begin
      if (srst) begin
         off_q   <= 8'h00;
         taken_q <= 1'b0;
      end else if (q_q == `CBU_Q2) begin
         off_q   <= dif.offset;
         taken_q <= act_q && dif.is_branch && dif.taken;
      end
   end

   // Q3: form the branch target from the address after the branch word
   always_ff @(posedge clk) begin
      if (srst) begin
         target_q <= `CBU_PC_RST;
      end else if (q_q == `CBU_Q3) begin
         target_q <= here_q + `CBU_STEP + off_ext;
      end
   end

   // Q4: write the PC if taken; otherwise report the sequential address
   always_ff @(posedge clk) begin
      if (srst) begin
         pc_wr_q  <= 1'b0;
         pc_val_q <= `CBU_PC_RST;
         done_q   <= 1'b0;
      end else if ((q_q == `CBU_Q4) && act_q) begin
         pc_wr_q  <= taken_q;
         pc_val_q <= taken_q ? target_q : here_q + `CBU_STEP;
         done_q   <= 1'b1;
      end else begin
         pc_wr_q  <= 1'b0;
         done_q   <= 1'b0;
      end
   end

   // Flush covers the whole no-op cycle so fetch can squash the prefetched word
   always_ff @(posedge clk) begin
      if (srst) begin
         flush_q <= 1'b0;
      end else if (q_q == `CBU_Q4) begin
         flush_q <= act_q && taken_q && (state_q == CBU_ST_EXEC);
      end
   end

   // Outputs straight from flops
   assign quarter_o = q_q;
   assign pc_wr_o   = pc_wr_q;
   assign pc_val_o  = pc_val_q;
   assign flush_o   = flush_q;
   assign done_o    = done_q;
   assign taken_o   = flush_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // Condition nibble 7 with the branch opcode is a branch
   decode_hit_a: assert property (
      (word_q[15:12] == `CBU_OPC_BRANCH) && (word_q[11:8] == `CBU_COND_NEG_CLR)
      |-> dif.is_branch && (dif.cond == CBU_COND_NEGCLR) && (dif.offset == word_q[7:0]))
      else $error("branch word not decoded");

   neg_set_a: assert property (
      (q_q == `CBU_Q2) && act_q && (dif.cond == CBU_COND_NEGSET)
      |=> taken_q == $past(neg_q))
      else $error("negative-set condition wrong");

   carry_clr_a: assert property (
      (q_q == `CBU_Q2) && act_q && (dif.cond == CBU_COND_CARRYCLR)
      |=> taken_q == !$past(carry_q))
      else $error("carry-clear condition wrong");

   neg_clr_a: assert property (
      (q_q == `CBU_Q2) && act_q && (dif.cond == CBU_COND_NEGCLR)
      |=> taken_q == !$past(neg_q))
      else $error("negative-clear condition wrong");

   taken_pc_a: assert property (
      pc_wr_q |-> pc_val_q == here_q + `CBU_STEP + off_ext)
      else $error("taken target wrong");

   offset_ext_a: assert property (
      (q_q == `CBU_Q3) |=> (target_q - here_q - `CBU_STEP) == off_ext)
      else $error("offset not signed and doubled");

   nop_len_a: assert property (
      pc_wr_q |-> flush_q [*4] ##1 !flush_q)
      else $error("taken branch not two cycles");

   quarter_wr_a: assert property (
      $rose(done_q) |-> $past(q_q) == `CBU_Q4)
      else $error("PC written outside Q4");

   seq_pc_a: assert property (
      done_q && !pc_wr_q |-> !flush_q && (pc_val_q == here_q + `CBU_STEP))
      else $error("not-taken PC wrong");

   // The completion pulse of the taken branch itself overlaps the first flush quarter
   nop_quiet_a: assert property (
      flush_q |-> !act_q && (done_q == pc_wr_q))
      else $error("no-op cycle executed something");

   // A word offered at Q1 of the no-op cycle must never start work
   nop_drop_a: assert property (
      (q_q == `CBU_Q1) && (state_q == CBU_ST_NOP) |=> !act_q)
      else $error("prefetched word not dropped");

   // One completion pulse per accepted word, never two quarters long
   done_pulse_a: assert property (
      done_q |=> !done_q)
      else $error("completion pulse too long");

endmodule

// file: verilog/cbu_defs.svh
`ifndef CBU_DEFS_SVH
`define CBU_DEFS_SVH

// Opcode fields of a conditional relative branch word
`define CBU_OPC_BRANCH     4'hE
`define CBU_COND_NEG_SET   4'h6
`define CBU_COND_CARRY_CLR 4'h3
`define CBU_COND_NEG_CLR   4'h7

// Program counter width and the size of one program word in bytes
`define CBU_PC_W  21
`define CBU_STEP  21'h000002

// Quarter phases of one instruction cycle
`define CBU_Q1 2'h0
`define CBU_Q2 2'h1
`define CBU_Q3 2'h2
`define CBU_Q4 2'h3

// Reset values
`define CBU_PC_RST   21'h000000
`define CBU_WORD_RST 16'h0000

`endif

// file: verilog/cbu_pkg.sv
`include "cbu_defs.svh"

package cbu_pkg;

   // Condition selected by the second nibble of a branch word
   typedef enum logic [1:0] {
      CBU_COND_NONE,
      CBU_COND_NEGSET,
      CBU_COND_CARRYCLR,
      CBU_COND_NEGCLR
   } cbu_cond_e;

   // Instruction cycle kind
   typedef enum logic {
      CBU_ST_EXEC,
      CBU_ST_NOP
   } cbu_state_e;

   typedef logic [`CBU_PC_W-1:0] cbu_pc_t;

endpackage

// file: verilog/cbu_dec_if.sv
`timescale 1ns/1ps

interface cbu_dec_if;
   import cbu_pkg::*;

   logic [15:0] word;
   logic        neg;
   logic        carry;
   cbu_cond_e   cond;
   logic        is_branch;
   logic        taken;
   logic [7:0]  offset;

   modport dec (
      input  word,
      input  neg,
      input  carry,
      output cond,
      output is_branch,
      output taken,
      output offset
   );

   modport core (
      output word,
      output neg,
      output carry,
      input  cond,
      input  is_branch,
      input  taken,
      input  offset
   );
endinterface

// file: verilog/cbu_decode.sv
`timescale 1ns/1ps
`include "cbu_defs.svh"

module cbu_decode
   import cbu_pkg::*;
(
   cbu_dec_if.dec dif
);

   // Pure decode; the offset is the low byte whatever the condition
   always_comb begin
      dif.cond      = CBU_COND_NONE;
      dif.is_branch = 1'b0;
      dif.taken     = 1'b0;
      dif.offset    = dif.word[7:0];
      if (dif.word[15:12] == `CBU_OPC_BRANCH) begin
         case (dif.word[11:8])
            `CBU_COND_NEG_SET: begin
               dif.cond      = CBU_COND_NEGSET;
               dif.is_branch = 1'b1;
               dif.taken     = dif.neg;
            end
            `CBU_COND_CARRY_CLR: begin
               dif.cond      = CBU_COND_CARRYCLR;
               dif.is_branch = 1'b1;
               dif.taken     = !dif.carry;
            end
            `CBU_COND_NEG_CLR: begin
               dif.cond      = CBU_COND_NEGCLR;
               dif.is_branch = 1'b1;
               dif.taken     = !dif.neg;
            end
            default: begin
               dif.cond      = CBU_COND_NONE;    // Other branch kinds live elsewhere
               dif.is_branch = 1'b0;
            end
         endcase
      end
   end

endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps

module tb;
   import cbu_pkg::*;

   logic          clk;
   logic          srst;
   logic          instr_valid_i;
   logic [15:0]   instr_i;
   cbu_pc_t       pc_i;
   logic          flag_neg_i;
   logic          flag_carry_i;
   logic [1:0]    quarter_o;
   logic          pc_wr_o;
   cbu_pc_t       pc_val_o;
   logic          flush_o;
   logic          done_o;
   logic          taken_o;
   int            fail_count = 0;
   int            n_checks = 0;
   bit            tk_q[$];
   cbu_pc_t       pv_q[$];
   longint        t_q[$];
   int            fl_cnt = 0;
   cbu_pc_t       pv_last = '0;
   logic [1:0]    q_exp = 2'h0;
   logic [15:0]   dw[6] = '{16'hE67F, 16'hE680, 16'hE3FF, 16'hE701, 16'hE200, 16'h1234};
   logic [3:0]    cn[4] = '{4'h6, 4'h3, 4'h7, 4'h5};

   cbu_top DUT (
      .clk           (clk),
      .srst          (srst),
      .instr_valid_i (instr_valid_i),
      .instr_i       (instr_i),
      .pc_i          (pc_i),
      .flag_neg_i    (flag_neg_i),
      .flag_carry_i  (flag_carry_i),
      .quarter_o     (quarter_o),
      .pc_wr_o       (pc_wr_o),
      .pc_val_o      (pc_val_o),
      .flush_o       (flush_o),
      .done_o        (done_o),
      .taken_o       (taken_o)
   );

   // Core clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input bit ok, input string msg);
      n_checks++;
      if (!ok) begin
         fail_count++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   task automatic test_done();
      if (fail_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Reference decision, unknown opcodes count as not taken
   function automatic bit br_taken(input logic [15:0] w, input bit n, input bit c);
      if (w[15:12] != 4'hE) return 1'b0;
      case (w[11:8])
         4'h6: return n;
         4'h3: return !c;
         4'h7: return !n;
         default: return 1'b0;
      endcase
   endfunction

   // One word at the next Q1; random junk stays valid so a flush must drop it
   task automatic op(input logic [15:0] w, input cbu_pc_t p, input bit n, input bit c);
      bit tk;
      int off;
      instr_valid_i <= 1'b1;
      instr_i       <= w;
      pc_i          <= p;
      flag_neg_i    <= n;
      flag_carry_i  <= c;
      @(posedge clk);
      tk  = br_taken(w, n, c);
      off = tk ? 2 * int'($signed(w[7:0])) : 0;
      tk_q.push_back(tk);
      pv_q.push_back(cbu_pc_t'(int'(p) + 2 + off));
      t_q.push_back($time);
      instr_i <= 16'($urandom);
      pc_i    <= cbu_pc_t'($urandom << 1);
      repeat (tk ? 7 : 3) @(posedge clk);
   endtask

   // Compare against the queued expectations once each edge has settled
   always @(posedge clk) begin
      bit rs;
      rs = srst;
      #1;
      q_exp = rs ? 2'h0 : q_exp + 2'h1;
      if (fl_cnt > 0) fl_cnt--;
      if (rs) fl_cnt = 0;
      if (rs) pv_last = '0;
      check(quarter_o === q_exp, "quarter phase");
      check(done_o === 1'b1 || pc_wr_o === 1'b0, "stray pc write");
      if (done_o === 1'b1) begin
         if (tk_q.size() == 0) begin
            check(1'b0, "unexpected completion");
         end else begin
            check($time - t_q[0] == 301, "completion latency");
            check(pc_wr_o === tk_q[0], "pc write strobe");
            check(pc_val_o === pv_q[0], "pc value");
            if (tk_q[0]) fl_cnt = 4;
            pv_last = pv_q[0];
            void'(tk_q.pop_front());
            void'(pv_q.pop_front());
            void'(t_q.pop_front());
         end
      end else begin
         check(pc_val_o === pv_last, "pc value not held");
      end
      check(flush_o === (fl_cnt > 0), "flush level");
      check(taken_o === (fl_cnt > 0), "taken level");
   end

   // Hang guard
   initial begin
      #200000;
      fail_count++;
      test_done();
   end

   task automatic drain();
      instr_valid_i <= 1'b0;
      instr_i       <= 16'hE600;
      flag_neg_i    <= 1'b1;
      repeat (12) @(posedge clk);
      check(tk_q.size() == 0, "missing completion");
   endtask

   // Main sequence: each of the six table words with every flag pair, then random words, then a reset
   initial begin
      srst          = 1'b1;
      instr_valid_i = 1'b0;
      instr_i       = 16'h0000;
      pc_i          = '0;
      flag_neg_i    = 1'b0;
      flag_carry_i  = 1'b0;
      void'($urandom(32'h4471));
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 24; i++) begin
         op(dw[i / 4], cbu_pc_t'(21'h1FFFC0 + i * 4), i[0], i[1]);
      end
      for (int i = 0; i < 40; i++) begin
         op({4'hE, cn[$urandom % 4], 8'($urandom)}, cbu_pc_t'($urandom << 1),
            1'($urandom), 1'($urandom));
      end
      drain();
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      op(16'hE780, 21'h000000, 1'b0, 1'b1);
      op(16'hE300, 21'h000010, 1'b1, 1'b1);
      drain();
      test_done();
   end
endmodule
